// >>> bench/led_ctrl_checker.sv
/* Assertions on the top-level pins of the LED driver control core.
   Assumes one clock, mclk, and ce held high by the surroundings. */
`timescale 1ns/100ps
`default_nettype none
module led_ctrl_checker (
   // Clock and reset
   input wire logic                  mclk,
   input wire logic                  rst_n,
   // Pins watched
   input wire led_ctrl_pkg::spi_in_t spi_in,
   input wire logic                  miso_oe,
   input wire logic                  shutdown_pin_n,
   input wire logic [17:0]           open_sense,
   input wire logic [17:0]           channel_output,
   input wire logic [17:0][7:0]      channel_scale,
   input wire logic [5:0]            global_current_level,
   input wire logic                  current_range_select,
   input wire logic                  spread_enable,
   input wire logic [1:0]            spread_range,
   input wire logic                  interrupt_out_n
);
   import led_ctrl_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   property p_reset_dark;
      disable iff (1'b0) !rst_n |=> channel_output == '0 &&
         interrupt_out_n && channel_scale == '0 && global_current_level == '0;
   endproperty
   // Settings move only through a host frame, never by shutdown.
   property p_scale_host;
      $past(rst_n) && !$stable(channel_scale) |-> !$past(spi_in.cs_n, 2);
   endproperty
   property p_level_host;
      $past(rst_n) && $changed(global_current_level) |->
         !$past(spi_in.cs_n, 2);
   endproperty
   property p_mode_host;
      $past(rst_n) && $changed({current_range_select, spread_enable,
         spread_range}) |-> !$past(spi_in.cs_n, 2);
   endproperty
   property p_pin_dark;
      !shutdown_pin_n [*3] |-> channel_output == '0;
   endproperty
   property p_pin_abort;
      $rose(shutdown_pin_n) |-> ##[1:3] !miso_oe;
   endproperty
   property p_idle_quiet;
      spi_in.cs_n [*2] |-> !miso_oe;
   endproperty
   property p_int_cause;
      $fell(interrupt_out_n) |-> !$past(spi_in.cs_n, 2) ||
         $past(|open_sense, 2);
   endproperty
   // ---------------------------------------------------------------
   // Assertions and covers
   // ---------------------------------------------------------------
   a_reset_dark: assert property (p_reset_dark)
      else $error("outputs not idle after reset");
   a_scale_host: assert property (p_scale_host)
      else $error("scale moved without host write");
   a_level_host: assert property (p_level_host)
      else $error("level moved without host write");
   a_mode_host: assert property (p_mode_host)
      else $error("mode moved without host write");
   a_pin_dark: assert property (p_pin_dark)
      else $error("channel on while shutdown pin low");
   a_pin_abort: assert property (p_pin_abort)
      else $error("serial port not reset by pin rise");
   a_idle_quiet: assert property (p_idle_quiet)
      else $error("miso driven outside a frame");
   a_int_cause: assert property (p_int_cause)
      else $error("interrupt fell without cause");
   c_lit: cover property ($rose(channel_output[0]));
   c_int: cover property ($fell(interrupt_out_n));
   c_range: cover property ($rose(current_range_select));
endmodule
bind led_driver_control_core led_ctrl_checker checker_inst (
   .mclk(mclk), .rst_n(rst_n), .spi_in(spi_in), .miso_oe(miso_oe),
   .shutdown_pin_n(shutdown_pin_n), .open_sense(open_sense),
   .channel_output(channel_output), .channel_scale(channel_scale),
   .global_current_level(global_current_level),
   .current_range_select(current_range_select),
   .spread_enable(spread_enable), .spread_range(spread_range),
   .interrupt_out_n(interrupt_out_n));
`default_nettype wire

// >>> bench/led_driver_control_core_tb.sv
/* Testbench for the LED driver control core: register tests through the
   host model. Assumes the checker file binds itself to the design. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin \
   fails++; $display("Error %s expected %0h seen %0h", nm, exp, got); end end
module led_driver_control_core_tb;
   import led_ctrl_pkg::*;
   logic             mclk;
   logic             rst_n;
   logic             shutdown_pin_n;
   logic             miso;
   logic             miso_oe;
   logic             range_sel;
   logic             spread_en;
   logic             int_n;
   logic [1:0]       spread_rng;
   logic [5:0]       level;
   logic [17:0]      open_sense;
   logic [17:0]      ch_on;
   logic [17:0][7:0] scale;
   spi_in_t          spi_in;
   int               fails = 0;
   int               n_tests = 0;
   int               cnt;
   led_driver_control_core #(.BLINK_STEP_CYCLES(4))
      led_driver_control_core_inst (.mclk(mclk), .rst_n(rst_n), .ce(1'b1),
      .spi_in(spi_in), .miso(miso), .miso_oe(miso_oe),
      .shutdown_pin_n(shutdown_pin_n), .open_sense(open_sense),
      .channel_output(ch_on), .channel_scale(scale),
      .global_current_level(level), .current_range_select(range_sel),
      .spread_enable(spread_en), .spread_range(spread_rng),
      .interrupt_out_n(int_n));
   spi_host_model spi_host_model_inst (.mclk(mclk), .miso(miso),
      .spi_in(spi_in));
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   initial begin
      repeat (100000) @(posedge mclk);
      fails++;
      results();
   end
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      spi_host_model_inst.frame(8'h00, a, d, r);
   endtask
   task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] r;
      spi_host_model_inst.frame(8'h80, a, 8'h00, r);
      `CHK($sformatf("reg %h", a), exp, r)
   endtask
   // One full fast PWM period is 256 steps of 7 cycles.
   task automatic count_on(input int k);
      cnt = 0;
      repeat (4) @(negedge mclk);
      repeat (PWM_STEPS * 7) begin
         @(negedge mclk);
         if (ch_on[k] === 1'b1) cnt++;
      end
   endtask
   task automatic results;
      $display("Checks %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      shutdown_pin_n = 1'b1;
      open_sense = '0;
      repeat (12) @(negedge mclk);
      rst_n = 1'b1;
      @(negedge mclk);
      `CHK("channel_output", 18'h0, ch_on)
      chk_rd(ADDR_CONFIG, RESET_BYTE);
      chk_rd(ADDR_PWM_COMMIT, 8'h00);
      chk_rd(ADDR_RESTORE, 8'h00);
      $display("Test defaults done");
      wr(ADDR_GLOBAL_LEVEL, 8'h20);
      wr(ADDR_CONFIG, 8'h23);
      `CHK("global_current_level", 6'h20, level)
      `CHK("current_range_select", 1'b1, range_sel)
      for (int r = 0; r < 4; r++) begin
         wr(ADDR_SPREAD, 8'(8'h10 + 4 * r));
         `CHK("spread_range", 2'(r), spread_rng)
         `CHK("spread_enable", 1'b1, spread_en)
      end
      wr(ADDR_SCALE_FIRST, 8'h80);
      wr(ADDR_SCALE_LAST, 8'h55);
      `CHK("channel_scale 0", 8'h00, scale[0])
      chk_rd(ADDR_SCALE_FIRST, 8'h80);
      wr(ADDR_SCALE_COMMIT, 8'h01);
      `CHK("channel_scale 0", 8'h00, scale[0])
      wr(ADDR_SCALE_COMMIT, COMMIT_VALUE);
      `CHK("channel_scale 0", 8'h80, scale[0])
      `CHK("channel_scale 17", 8'h55, scale[17])
      $display("Test modes and scaling done");
      wr(ADDR_PWM_FIRST, 8'h40);
      wr(ADDR_PWM_LAST, 8'hff);
      count_on(0);
      `CHK("on cycles 0", 0, cnt)
      wr(ADDR_PWM_COMMIT, COMMIT_VALUE);
      count_on(0);
      `CHK("on cycles 0", 64 * 7, cnt)
      count_on(17);
      `CHK("on cycles 17", 255 * 7, cnt)
      wr(ADDR_CONFIG, 8'h22);
      count_on(17);
      `CHK("on cycles 17", 0, cnt)
      chk_rd(ADDR_PWM_LAST, 8'hff);
      wr(ADDR_CONFIG, 8'h23);
      shutdown_pin_n = 1'b0;
      count_on(17);
      `CHK("on cycles 17", 0, cnt)
      chk_rd(ADDR_GLOBAL_LEVEL, 8'h20);
      fork
         wr(ADDR_CONFIG, 8'h00);
         #1160 shutdown_pin_n = 1'b1;
      join
      count_on(17);
      `CHK("on cycles 17", 255 * 7, cnt)
      $display("Test pwm and shutdown done");
      open_sense = 18'h20001;
      wr(ADDR_OPEN_CTRL, 8'h01);
      chk_rd(ADDR_OPEN_FIRST, 8'h01);
      chk_rd(ADDR_OPEN_LAST, 8'h02);
      `CHK("interrupt_out_n", 1'b1, int_n)
      wr(ADDR_OPEN_CTRL, 8'h03);
      `CHK("interrupt_out_n", 1'b0, int_n)
      wr(ADDR_OPEN_CTRL, 8'h02);
      open_sense = '0;
      chk_rd(ADDR_OPEN_FIRST, 8'h01);
      wr(ADDR_OPEN_CTRL, 8'h03);
      chk_rd(ADDR_OPEN_FIRST, 8'h00);
      `CHK("interrupt_out_n", 1'b1, int_n)
      $display("Test open detect done");
      wr(ADDR_BLINK_FIRST, 8'h01);
      wr(ADDR_BLINK_DUTY, 8'h00);
      count_on(0);
      `CHK("on cycles 0", 64 * 7, cnt)
      wr(ADDR_PWM_COMMIT, COMMIT_VALUE);
      count_on(0);
      `CHK("on cycles 0", 0, cnt)
      count_on(17);
      `CHK("on cycles 17", 255 * 7, cnt)
      wr(ADDR_RESTORE, 8'h55);
      `CHK("global_current_level", 6'h20, level)
      wr(ADDR_RESTORE, RESTORE_KEY);
      `CHK("global_current_level", 6'h00, level)
      `CHK("channel_scale 0", 8'h00, scale[0])
      `CHK("channel_output", 18'h0, ch_on)
      chk_rd(ADDR_CONFIG, RESET_BYTE);
      $display("Test blink and restore done");
      results();
   end
endmodule
`default_nettype wire

// >>> bench/spi_host_model.sv
/* Host model: runs mode 0 serial frames of one data byte each.
   Assumes the device samples sclk on mclk, each phase two cycles or more. */
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
   // Clock and returned data
   input  wire logic                mclk,
   input  wire logic                miso,
   // Serial lines to the device
   output var led_ctrl_pkg::spi_in_t spi_in
);
   import led_ctrl_pkg::*;
   // ---------------------------------------------------------------
   // Frame tasks
   // ---------------------------------------------------------------
   // The clock stands low between frames.
   initial spi_in = '{sclk: 1'b0, cs_n: 1'b1, mosi: 1'b0};
   task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         spi_in.mosi = tx[i];
         repeat (3) @(negedge mclk);
         rx[i] = miso;
         spi_in.sclk = 1'b1;
         repeat (2) @(negedge mclk);
         spi_in.sclk = 1'b0;
      end
   endtask
   task automatic frame(input logic [7:0] cmd, input logic [7:0] addr,
                        input logic [7:0] data, output logic [7:0] rd);
      logic [7:0] junk;
      spi_in.cs_n = 1'b0;
      repeat (2) @(negedge mclk);
      byte_io(cmd, junk);
      byte_io(addr, junk);
      byte_io(data, rd);
      repeat (2) @(negedge mclk);
      spi_in.cs_n = 1'b1;
      // A released line must not keep showing the last bit.
      spi_in.mosi = ~spi_in.mosi;
      repeat (4) @(negedge mclk);
   endtask
endmodule
`default_nettype wire

// >>> core/led_driver_control_core.sv
/*
 * LED driver control core: serial register port, staged duty, blink and
 * scaling settings with commit registers, restore key, shutdown handling,
 * PWM and blink generation, open-LED status and its interrupt pin.
 * Assumes all pins are synchronous to mclk; the analog current sources sit
 * outside and take the channel gates and current codes driven here.
 */
`timescale 1ns/100ps
`default_nettype none

module led_driver_control_core #(
   parameter int unsigned BLINK_STEP_CYCLES = led_ctrl_pkg::BLINK_DIV
) (
   // Clock, reset and enable
   input  wire  logic                      mclk,
   input  wire  logic                      rst_n,
   input  wire  logic                      ce,
   // Host serial port
   input  wire  led_ctrl_pkg::spi_in_t     spi_in,
   output logic                            miso,
   output logic                            miso_oe,
   // Shutdown pin and open-LED sense
   input  wire  logic                      shutdown_pin_n,
   input  wire  logic [17:0]               open_sense,
   // Outputs to the current sources and the interrupt pin
   output logic [17:0]                     channel_output,
   output logic [17:0][7:0]                channel_scale,
   output logic [5:0]                      global_current_level,
   output logic                            current_range_select,
   output logic                            spread_enable,
   output logic [1:0]                      spread_range,
   output logic                            interrupt_out_n
);
   import led_ctrl_pkg::*;

   // ---------------------------------------------------------------------
   // Register state
   // ---------------------------------------------------------------------
   logic [7:0]        config_ff;
   logic [7:0]        global_ff;
   logic [7:0]        open_ctrl_ff;
   logic [7:0]        spread_ff;
   logic [17:0][7:0]  scale_pend_ff;
   logic [17:0][7:0]  scale_act_ff;
   logic [17:0][7:0]  pwm_pend_ff;
   logic [17:0][7:0]  pwm_act_ff;
   logic [17:0]       blink_pend_ff;
   logic [17:0]       blink_act_ff;
   logic [7:0]        rate_pend_ff;
   logic [7:0]        rate_act_ff;
   logic [7:0]        duty_pend_ff;
   logic [7:0]        duty_act_ff;
   logic [23:0]       open_stat_ff;

   // ---------------------------------------------------------------------
   // Serial port state
   // ---------------------------------------------------------------------
   spi_state_t  spi_state_ff;
   logic        sclk_prev_ff;
   logic        pin_prev_ff;
   logic [2:0]  bit_cnt_ff;
   logic [6:0]  rx_sh_ff;
   logic [7:0]  tx_sh_ff;
   logic        is_read_ff;
   logic [7:0]  addr_ff;
   logic        wr_stb_ff;
   logic [7:0]  wr_addr_ff;
   logic [7:0]  wr_data_ff;

   logic        sclk_rise;
   logic        sclk_fall;
   logic        pin_rise;
   logic        byte_done;
   logic [7:0]  rx_byte;
   logic [7:0]  rd_addr;
   logic [7:0]  rd_val;
   logic [23:0] blink_img;

   assign sclk_rise = spi_in.sclk & ~sclk_prev_ff;
   assign sclk_fall = ~spi_in.sclk & sclk_prev_ff;
   assign pin_rise  = shutdown_pin_n & ~pin_prev_ff;
   assign byte_done = sclk_rise & ~spi_in.cs_n & (bit_cnt_ff == 3'h7);
   assign rx_byte   = {rx_sh_ff, spi_in.mosi};
   assign rd_addr   = (spi_state_ff == SPI_ADDR) ? rx_byte : addr_ff + 8'h01;

   // ---------------------------------------------------------------------
   // Serial frame: command byte, address byte, then data with increment
   // ---------------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sclk_prev_ff <= 1'b0;
         pin_prev_ff  <= 1'b1;
      end else if (ce) begin
         sclk_prev_ff <= spi_in.sclk;
         pin_prev_ff  <= shutdown_pin_n;
      end
   end

   // A pin rise drops any half-done frame so the host can resync cleanly.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         spi_state_ff <= SPI_CMD;
         bit_cnt_ff   <= 3'h0;
         rx_sh_ff     <= 7'h00;
         tx_sh_ff     <= RESET_BYTE;
         is_read_ff   <= 1'b0;
         addr_ff      <= RESET_BYTE;
         wr_stb_ff    <= 1'b0;
         wr_addr_ff   <= RESET_BYTE;
         wr_data_ff   <= RESET_BYTE;
         miso         <= 1'b0;
         miso_oe      <= 1'b0;
      end else if (ce) begin
         wr_stb_ff <= 1'b0;
         if (pin_rise || spi_in.cs_n) begin
            spi_state_ff <= SPI_CMD;
            bit_cnt_ff   <= 3'h0;
            is_read_ff   <= 1'b0;
            miso_oe      <= 1'b0;
         end else begin
            miso_oe <= is_read_ff && (spi_state_ff == SPI_DATA);
            if (sclk_fall) begin
               miso     <= tx_sh_ff[7];
               tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
            end
            if (sclk_rise) begin
               bit_cnt_ff <= bit_cnt_ff + 3'h1;
               rx_sh_ff   <= rx_byte[6:0];
            end
            if (byte_done) begin
               unique case (spi_state_ff)
                  SPI_CMD: begin
                     is_read_ff   <= rx_byte[CMD_READ_BIT];
                     spi_state_ff <= SPI_ADDR;
                  end
                  SPI_ADDR: begin
                     addr_ff      <= rx_byte;
                     tx_sh_ff     <= rd_val;
                     spi_state_ff <= SPI_DATA;
                  end
                  SPI_DATA: begin
                     if (is_read_ff) begin
                        addr_ff  <= rd_addr;
                        tx_sh_ff <= rd_val;
                     end else begin
                        wr_stb_ff  <= 1'b1;
                        wr_addr_ff <= addr_ff;
                        wr_data_ff <= rx_byte;
                        addr_ff    <= addr_ff + 8'h01;
                     end
                  end
                  default: spi_state_ff <= SPI_CMD;
               endcase
            end
         end
      end
   end

   // ---------------------------------------------------------------------
   // Read mux
   // ---------------------------------------------------------------------
   always_comb begin
      for (int k = 0; k < 3; k++) begin
         blink_img[k*8 +: 8] = {1'b0,
            blink_pend_ff[k*CH_PER_BYTE+CH_PER_NIBBLE +: CH_PER_NIBBLE],
            1'b0, blink_pend_ff[k*CH_PER_BYTE +: CH_PER_NIBBLE]};
      end
   end

   // Commit and restore registers fall to the default and read as zero.
   always_comb begin
      rd_val = RESET_BYTE;
      if (rd_addr == ADDR_CONFIG) begin
         rd_val = config_ff;
      end else if (rd_addr == ADDR_GLOBAL_LEVEL) begin
         rd_val = global_ff;
      end else if (rd_addr >= ADDR_SCALE_FIRST && rd_addr <= ADDR_SCALE_LAST)
      begin
         rd_val = scale_pend_ff[5'(rd_addr - ADDR_SCALE_FIRST)];
      end else if (rd_addr == ADDR_OPEN_CTRL) begin
         rd_val = open_ctrl_ff;
      end else if (rd_addr == ADDR_SPREAD) begin
         rd_val = spread_ff;
      end else if (rd_addr >= ADDR_PWM_FIRST && rd_addr <= ADDR_PWM_LAST) begin
         rd_val = pwm_pend_ff[5'(rd_addr - ADDR_PWM_FIRST)];
      end else if (rd_addr >= ADDR_BLINK_FIRST && rd_addr <= ADDR_BLINK_LAST)
      begin
         rd_val = blink_img[8*(2'(rd_addr - ADDR_BLINK_FIRST)) +: 8];
      end else if (rd_addr == ADDR_BLINK_RATE) begin
         rd_val = rate_pend_ff;
      end else if (rd_addr == ADDR_BLINK_DUTY) begin
         rd_val = duty_pend_ff;
      end else if (rd_addr >= ADDR_OPEN_FIRST && rd_addr <= ADDR_OPEN_LAST)
      begin
         rd_val = open_stat_ff[8*(2'(rd_addr - ADDR_OPEN_FIRST)) +: 8];
      end
   end

   // ---------------------------------------------------------------------
   // Register writes, commits and restore
   // ---------------------------------------------------------------------
   // Shutdown leaves this block alone, so contents survive it.
   always_ff @(posedge mclk) begin
      if (!rst_n || (ce && wr_stb_ff && wr_addr_ff == ADDR_RESTORE
                     && wr_data_ff == RESTORE_KEY)) begin
         config_ff     <= RESET_BYTE;
         global_ff     <= RESET_BYTE;
         open_ctrl_ff  <= RESET_BYTE;
         spread_ff     <= RESET_BYTE;
         scale_pend_ff <= '0;
         scale_act_ff  <= '0;
         pwm_pend_ff   <= '0;
         pwm_act_ff    <= '0;
         blink_pend_ff <= '0;
         blink_act_ff  <= '0;
         rate_pend_ff  <= RESET_BYTE;
         rate_act_ff   <= RESET_BYTE;
         duty_pend_ff  <= RESET_BYTE;
         duty_act_ff   <= RESET_BYTE;
      end else if (ce && wr_stb_ff) begin
         if (wr_addr_ff == ADDR_CONFIG) begin
            config_ff <= wr_data_ff;
         end
         if (wr_addr_ff == ADDR_GLOBAL_LEVEL) begin
            global_ff <= wr_data_ff;
         end
         if (wr_addr_ff == ADDR_OPEN_CTRL) begin
            open_ctrl_ff <= wr_data_ff;
         end
         if (wr_addr_ff == ADDR_SPREAD) begin
            spread_ff <= wr_data_ff;
         end
         if (wr_addr_ff >= ADDR_SCALE_FIRST && wr_addr_ff <= ADDR_SCALE_LAST)
         begin
            scale_pend_ff[5'(wr_addr_ff - ADDR_SCALE_FIRST)] <= wr_data_ff;
         end
         if (wr_addr_ff >= ADDR_PWM_FIRST && wr_addr_ff <= ADDR_PWM_LAST) begin
            pwm_pend_ff[5'(wr_addr_ff - ADDR_PWM_FIRST)] <= wr_data_ff;
         end
         for (int k = 0; k < 3; k++) begin
            if (wr_addr_ff == ADDR_BLINK_FIRST + 8'(k)) begin
               blink_pend_ff[k*CH_PER_BYTE +: CH_PER_NIBBLE] <=
                  wr_data_ff[CH_PER_NIBBLE-1:0];
               blink_pend_ff[k*CH_PER_BYTE+CH_PER_NIBBLE +: CH_PER_NIBBLE] <=
                  wr_data_ff[CH_PER_NIBBLE+3:4];
            end
         end
         if (wr_addr_ff == ADDR_BLINK_RATE) begin
            rate_pend_ff <= wr_data_ff;
         end
         if (wr_addr_ff == ADDR_BLINK_DUTY) begin
            duty_pend_ff <= wr_data_ff;
         end
         if (wr_addr_ff == ADDR_SCALE_COMMIT && wr_data_ff == COMMIT_VALUE)
         begin
            scale_act_ff <= scale_pend_ff;
         end
         if (wr_addr_ff == ADDR_PWM_COMMIT && wr_data_ff == COMMIT_VALUE) begin
            pwm_act_ff   <= pwm_pend_ff;
            blink_act_ff <= blink_pend_ff;
            rate_act_ff  <= rate_pend_ff;
            duty_act_ff  <= duty_pend_ff;
         end
      end
   end

   // ---------------------------------------------------------------------
   // PWM and blink timebases
   // ---------------------------------------------------------------------
   logic [9:0]  pwm_pre_ff;
   logic [7:0]  pwm_cnt_ff;
   logic [13:0] blink_pre_ff;
   logic [7:0]  blink_sub_ff;
   logic [7:0]  blink_phase_ff;
   logic [9:0]  pwm_div;
   logic        blink_on;

   assign pwm_div  = config_ff[CFG_FREQ_BIT] ? 10'(PWM_FAST_DIV - 1)
                                             : 10'(PWM_SLOW_DIV - 1);
   assign blink_on = blink_phase_ff < duty_act_ff;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pwm_pre_ff <= '0;
         pwm_cnt_ff <= '0;
      end else if (ce) begin
         if (pwm_pre_ff >= pwm_div) begin
            pwm_pre_ff <= '0;
            pwm_cnt_ff <= pwm_cnt_ff + 8'h01;
         end else begin
            pwm_pre_ff <= pwm_pre_ff + 10'h001;
         end
      end
   end

   // One blink period is 256 phase steps of (code+1) base steps each.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         blink_pre_ff   <= '0;
         blink_sub_ff   <= '0;
         blink_phase_ff <= '0;
      end else if (ce) begin
         if (blink_pre_ff >= 14'(BLINK_STEP_CYCLES - 1)) begin
            blink_pre_ff <= '0;
            if (blink_sub_ff >= rate_act_ff) begin
               blink_sub_ff   <= '0;
               blink_phase_ff <= blink_phase_ff + 8'h01;
            end else begin
               blink_sub_ff <= blink_sub_ff + 8'h01;
            end
         end else begin
            blink_pre_ff <= blink_pre_ff + 14'h0001;
         end
      end
   end

   // ---------------------------------------------------------------------
   // Channel gates, current codes, open status and interrupt
   // ---------------------------------------------------------------------
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
         always_ff @(posedge mclk) begin
            if (!rst_n) begin
               channel_output[ch] <= 1'b0;
               channel_scale[ch]  <= '0;
            end else if (ce) begin
               channel_output[ch] <= config_ff[CFG_RUN_BIT] && shutdown_pin_n
                  && (pwm_cnt_ff < pwm_act_ff[ch])
                  && (!blink_act_ff[ch] || blink_on);
               channel_scale[ch]  <= scale_act_ff[ch];
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         global_current_level <= '0;
         current_range_select <= 1'b0;
         spread_enable        <= 1'b0;
         spread_range         <= 2'h0;
      end else if (ce) begin
         global_current_level <= global_ff[GLOBAL_MSB:0];
         current_range_select <= config_ff[CFG_RANGE_BIT];
         spread_enable        <= spread_ff[SPREAD_EN_BIT];
         spread_range         <= spread_ff[SPREAD_RNG_LSB +: 2];
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         open_stat_ff    <= '0;
         interrupt_out_n <= 1'b1;
      end else if (ce) begin
         if (open_ctrl_ff[OPEN_EN_BIT]) begin
            open_stat_ff <= {6'h00, open_sense};
         end
         interrupt_out_n <= !(open_ctrl_ff[OPEN_REPORT_BIT]
                              && (|open_stat_ff));
      end
   end

endmodule

`default_nettype wire

// >>> include/led_ctrl_pkg.sv
/*
 * Package for the LED driver control core: register map, field positions,
 * reset values, keys and timing constants shared by the design and bench.
 * Assumes a 50 MHz core clock and a host that talks over a 4-wire serial
 * peripheral interface sampled synchronously to that clock.
 */
package led_ctrl_pkg;

   // ---------------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------------
   localparam int unsigned NUM_CH    = 18;
   localparam int unsigned PWM_STEPS = 256;

   // ---------------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------------
   localparam logic [7:0] ADDR_CONFIG       = 8'h00;
   localparam logic [7:0] ADDR_GLOBAL_LEVEL = 8'h01;
   localparam logic [7:0] ADDR_SCALE_FIRST  = 8'h02;
   localparam logic [7:0] ADDR_SCALE_LAST   = 8'h13;
   localparam logic [7:0] ADDR_OPEN_CTRL    = 8'h14;
   localparam logic [7:0] ADDR_SPREAD       = 8'h19;
   localparam logic [7:0] ADDR_PWM_FIRST    = 8'h1f;
   localparam logic [7:0] ADDR_PWM_LAST     = 8'h30;
   localparam logic [7:0] ADDR_BLINK_FIRST  = 8'h31;
   localparam logic [7:0] ADDR_BLINK_LAST   = 8'h33;
   localparam logic [7:0] ADDR_BLINK_RATE   = 8'h34;
   localparam logic [7:0] ADDR_BLINK_DUTY   = 8'h35;
   localparam logic [7:0] ADDR_SCALE_COMMIT = 8'h36;
   localparam logic [7:0] ADDR_PWM_COMMIT   = 8'h37;
   localparam logic [7:0] ADDR_RESTORE      = 8'h3f;
   localparam logic [7:0] ADDR_OPEN_FIRST   = 8'h95;
   localparam logic [7:0] ADDR_OPEN_LAST    = 8'h97;

   // ---------------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------------
   localparam int unsigned CFG_RUN_BIT     = 0;
   localparam int unsigned CFG_FREQ_BIT    = 1;
   localparam int unsigned CFG_RANGE_BIT   = 5;
   localparam int unsigned OPEN_EN_BIT     = 0;
   localparam int unsigned OPEN_REPORT_BIT = 1;
   localparam int unsigned SPREAD_EN_BIT   = 4;
   localparam int unsigned SPREAD_RNG_LSB  = 2;
   localparam int unsigned GLOBAL_MSB      = 5;
   localparam int unsigned CH_PER_BYTE     = 6;
   localparam int unsigned CH_PER_NIBBLE   = 3;
   localparam int unsigned CMD_READ_BIT    = 7;

   // ---------------------------------------------------------------------
   // Values and keys
   // ---------------------------------------------------------------------
   localparam logic [7:0] RESET_BYTE   = 8'h00;
   localparam logic [7:0] COMMIT_VALUE = 8'h00;
   localparam logic [7:0] RESTORE_KEY  = 8'hae;

   // ---------------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------------
   localparam int unsigned CLK_HZ       = 50_000_000;
   localparam int unsigned PWM_SLOW_HZ  = 200;
   localparam int unsigned PWM_FAST_HZ  = 25_000;
   localparam int unsigned BLINK_BASE_HZ = 24;
   localparam int unsigned PWM_SLOW_DIV = CLK_HZ / (PWM_SLOW_HZ * PWM_STEPS);
   localparam int unsigned PWM_FAST_DIV = CLK_HZ / (PWM_FAST_HZ * PWM_STEPS);
   localparam int unsigned BLINK_DIV    = CLK_HZ / (BLINK_BASE_HZ * PWM_STEPS);

   // ---------------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------------
   typedef struct packed {
      logic sclk;
      logic cs_n;
      logic mosi;
   } spi_in_t;

   typedef enum logic [1:0] {
      SPI_CMD  = 2'b00,
      SPI_ADDR = 2'b01,
      SPI_DATA = 2'b10
   } spi_state_t;

endpackage
